/* hdl/ccu_pkg.sv */
// package: register map, fields and reset values of the compare unit
package ccu_pkg;
  // register byte addresses on the AXI4-Lite bus
  localparam logic [7:0] ADDR_CCP_CONTROL   = 8'h00;
  localparam logic [7:0] ADDR_CMP_LOW       = 8'h04;
  localparam logic [7:0] ADDR_CMP_HIGH      = 8'h08;
  localparam logic [7:0] ADDR_IRQ_ENABLE    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_FLAGS     = 8'h10;
  localparam logic [7:0] ADDR_T1_CONTROL    = 8'h14;
  localparam logic [7:0] ADDR_T1_LOW        = 8'h18;
  localparam logic [7:0] ADDR_T1_HIGH       = 8'h1C;
  localparam logic [7:0] ADDR_ALT_PIN       = 8'h20;
  localparam logic [7:0] ADDR_PIN_DIR       = 8'h24;
  // field positions
  localparam int MODE_LSB        = 0;
  localparam int CCP_FLAG_BIT    = 2;
  localparam int T1_FLAG_BIT     = 0;
  localparam int T1_ON_BIT       = 0;
  localparam int ALT_SEL_BIT     = 0;
  localparam int PIN_DIR_BIT     = 0;
  // reset values
  localparam logic [7:0]  RST_BYTE     = 8'h00;
  localparam logic [7:0]  RST_PIN_DIR  = 8'h01;
  localparam logic [15:0] RST_WORD     = 16'h0000;
  // timer prescale: timer ticks at system clock divided by four
  localparam int T1_DIV = 4;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // compare mode codes
  typedef enum logic [3:0] {
    MODE_OFF     = 4'b0000,
    MODE_TOGGLE  = 4'b0010,
    MODE_SET     = 4'b1000,
    MODE_CLEAR   = 4'b1001,
    MODE_SWIRQ   = 4'b1010,
    MODE_SPECIAL = 4'b1011
  } ccu_mode_t;
endpackage

/* hdl/ccu_tick_div.sv */
// module: divider making the timer-one tick enable from the system clock
`timescale 1ns/10ps
module ccu_tick_div #(
  parameter int DIV = ccu_pkg::T1_DIV
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic srst,
  // control and tick
  input  wire logic run,
  output logic      tick
);
  import ccu_pkg::*;
  logic [$clog2(DIV)-1:0] cnt_q;

  always_ff @(posedge ref_clk) begin
    if (srst || !run) begin
      cnt_q <= '0;
    end else if (cnt_q == ($clog2(DIV))'(DIV - 1)) begin
      cnt_q <= '0;
    end else begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  assign tick = run && (cnt_q == ($clog2(DIV))'(DIV - 1));
endmodule

/* hdl/ccu_compare_unit.sv */
// module: compare unit with timer one, register file and AXI4-Lite slave
// Notes on behaviour
// - all sixteen compare bits are matched against the timer count
// - mode field picks toggle, set, clear, special trigger or interrupt only
// - every match in one of the five compare modes sets the unit interrupt flag; software clears it
// - writing zero to the control register forces the output latch low
// - interrupt-only mode leaves the pin alone, match sets flag only
// - special trigger resets the timer and starts a converter conversion
// - trigger pulses at once; count clears at next timer tick
// - trigger reset never sets the timer overflow flag
// - losing the match before that tick cancels the pending reset
// - timer halts while sleeping and matches are not detected; bus writes still take effect
// - alternate select bit routes the unit pin to the other location
//
// The AXI4-Lite register port and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module ccu_compare_unit (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  // AXI4-Lite write address and data
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  // AXI4-Lite read
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // system
  input  wire logic        sleepMode,
  input  wire logic        adcEnabled,
  output logic             adcStart,
  output logic             specialTrigger,
  output logic             ccpIrqFlag,
  // unit pin at two locations
  output logic             ccpPinMain,
  output logic             ccpPinMainOe,
  output logic             ccpPinAlt,
  output logic             ccpPinAltOe
);
  import ccu_pkg::*;

  logic [7:0]  ctrl_q;
  logic [15:0] cmp_q;
  logic [7:0]  irqEn_q;
  logic        ccpFlag_q;
  logic        t1Flag_q;
  logic [7:0]  t1Ctrl_q;
  logic [15:0] t1Cnt_q;
  logic        altSel_q;
  logic        pinDir_q;
  logic        outLatch_q;
  logic        match_q;
  logic        rstPend_q;
  logic        tick;
  logic        match;
  logic        matchRise;
  logic [3:0]  mode;
  logic        pinOwned;
  logic        pinDrive;

  // bus state
  logic        awHeld_q;
  logic        wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  logic        wrGo;
  logic        wrHit;
  logic [31:0] rdMux;
  logic        rdHit;

  assign mode = ctrl_q[MODE_LSB +: 4];

  ccu_tick_div #(
    .DIV (T1_DIV)
  ) u_div (
    .ref_clk (ref_clk),
    .srst    (srst),
    .run     (t1Ctrl_q[T1_ON_BIT] && !sleepMode),
    .tick    (tick)
  );

  // ---------------- AXI4-Lite write path ----------------
  assign s_axi_awready = !awHeld_q && !s_axi_bvalid;
  assign s_axi_wready  = !wHeld_q && !s_axi_bvalid;
  assign wrGo          = awHeld_q && wHeld_q && !s_axi_bvalid;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= RST_BYTE;
      wData_q  <= '0;
      wStrb_q  <= '0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= s_axi_awaddr;
      end else if (wrGo) begin
        awHeld_q <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wHeld_q <= 1'b1;
        wData_q <= s_axi_wdata;
        wStrb_q <= s_axi_wstrb;
      end else if (wrGo) begin
        wHeld_q <= 1'b0;
      end
    end
  end

  always_comb begin
    case (awAddr_q)
      ADDR_CCP_CONTROL, ADDR_CMP_LOW, ADDR_CMP_HIGH, ADDR_IRQ_ENABLE,
      ADDR_IRQ_FLAGS, ADDR_T1_CONTROL, ADDR_T1_LOW, ADDR_T1_HIGH,
      ADDR_ALT_PIN, ADDR_PIN_DIR: wrHit = 1'b1;
      default: wrHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wrGo) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wrHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  logic wrByte;
  assign wrByte = wrGo && wStrb_q[0];

  // ---------------- software-written registers ----------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ctrl_q   <= RST_BYTE;
      irqEn_q  <= RST_BYTE;
      t1Ctrl_q <= RST_BYTE;
      altSel_q <= 1'b0;
      pinDir_q <= RST_PIN_DIR[PIN_DIR_BIT];
    end else if (wrByte) begin
      case (awAddr_q)
        ADDR_CCP_CONTROL: ctrl_q   <= wData_q[7:0];
        ADDR_IRQ_ENABLE:  irqEn_q  <= wData_q[7:0];
        ADDR_T1_CONTROL:  t1Ctrl_q <= wData_q[7:0];
        ADDR_ALT_PIN:     altSel_q <= wData_q[ALT_SEL_BIT];
        ADDR_PIN_DIR:     pinDir_q <= wData_q[PIN_DIR_BIT];
        default: ;
      endcase
    end
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      cmp_q <= RST_WORD;
    end else if (wrByte && awAddr_q == ADDR_CMP_LOW) begin
      cmp_q[7:0] <= wData_q[7:0];
    end else if (wrByte && awAddr_q == ADDR_CMP_HIGH) begin
      cmp_q[15:8] <= wData_q[7:0];
    end
  end

  // ---------------- compare and match edge ----------------
  assign match     = (t1Cnt_q == cmp_q);
  assign matchRise = match && !match_q && !sleepMode;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      match_q <= 1'b0;
    end else if (!sleepMode) begin
      match_q <= match;
    end
  end

  logic modeValid;
  always_comb begin
    case (mode)
      MODE_TOGGLE, MODE_SET, MODE_CLEAR, MODE_SWIRQ, MODE_SPECIAL:
        modeValid = 1'b1;
      default:
        modeValid = 1'b0;
    endcase
  end

  // special trigger pulses in the match cycle
  assign specialTrigger = matchRise && mode == MODE_SPECIAL;
  assign adcStart       = specialTrigger && adcEnabled;

  // ---------------- timer one ----------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      rstPend_q <= 1'b0;
    end else if (specialTrigger) begin
      rstPend_q <= 1'b1;
    end else if (tick || !match || mode != MODE_SPECIAL) begin
      rstPend_q <= 1'b0;
    end
  end

  logic t1Wrap;
  logic t1Clear;
  assign t1Clear = tick && rstPend_q && match;
  assign t1Wrap  = tick && !t1Clear && (t1Cnt_q == 16'hFFFF);

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      t1Cnt_q <= RST_WORD;
    end else if (wrByte && awAddr_q == ADDR_T1_LOW) begin
      t1Cnt_q[7:0] <= wData_q[7:0];
    end else if (wrByte && awAddr_q == ADDR_T1_HIGH) begin
      t1Cnt_q[15:8] <= wData_q[7:0];
    end else if (t1Clear) begin
      t1Cnt_q <= RST_WORD;
    end else if (tick) begin
      t1Cnt_q <= t1Cnt_q + 16'h0001;
    end
  end

  // ---------------- flags: set wins over clear ----------------
  logic flagWr;
  assign flagWr = wrByte && awAddr_q == ADDR_IRQ_FLAGS;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ccpFlag_q <= 1'b0;
      t1Flag_q  <= 1'b0;
    end else begin
      if (matchRise && modeValid) begin
        ccpFlag_q <= 1'b1;
      end else if (flagWr) begin
        ccpFlag_q <= wData_q[CCP_FLAG_BIT];
      end
      if (t1Wrap) begin
        t1Flag_q <= 1'b1;
      end else if (flagWr) begin
        t1Flag_q <= wData_q[T1_FLAG_BIT];
      end
    end
  end

  assign ccpIrqFlag = ccpFlag_q;

  // ---------------- output latch and pin ----------------
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      outLatch_q <= 1'b0;
    end else if (wrByte && awAddr_q == ADDR_CCP_CONTROL
                 && wData_q[7:0] == RST_BYTE) begin
      outLatch_q <= 1'b0;
    end else if (matchRise) begin
      case (mode)
        MODE_TOGGLE: outLatch_q <= !outLatch_q;
        MODE_SET:    outLatch_q <= 1'b1;
        MODE_CLEAR:  outLatch_q <= 1'b0;
        default:     outLatch_q <= outLatch_q;
      endcase
    end
  end

  assign pinOwned = (mode == MODE_TOGGLE || mode == MODE_SET
                     || mode == MODE_CLEAR);
  assign pinDrive = pinOwned && !pinDir_q;

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      ccpPinMain   <= 1'b0;
      ccpPinMainOe <= 1'b0;
      ccpPinAlt    <= 1'b0;
      ccpPinAltOe  <= 1'b0;
    end else begin
      ccpPinMain   <= outLatch_q && !altSel_q;
      ccpPinMainOe <= pinDrive && !altSel_q;
      ccpPinAlt    <= outLatch_q && altSel_q;
      ccpPinAltOe  <= pinDrive && altSel_q;
    end
  end

  // ---------------- AXI4-Lite read path ----------------
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    rdHit = 1'b1;
    rdMux = '0;
    case (s_axi_araddr)
      ADDR_CCP_CONTROL: rdMux[7:0] = ctrl_q;
      ADDR_CMP_LOW:     rdMux[7:0] = cmp_q[7:0];
      ADDR_CMP_HIGH:    rdMux[7:0] = cmp_q[15:8];
      ADDR_IRQ_ENABLE:  rdMux[7:0] = irqEn_q;
      ADDR_IRQ_FLAGS: begin
        rdMux[CCP_FLAG_BIT] = ccpFlag_q;
        rdMux[T1_FLAG_BIT]  = t1Flag_q;
      end
      ADDR_T1_CONTROL:  rdMux[7:0] = t1Ctrl_q;
      ADDR_T1_LOW:      rdMux[7:0] = t1Cnt_q[7:0];
      ADDR_T1_HIGH:     rdMux[7:0] = t1Cnt_q[15:8];
      ADDR_ALT_PIN:     rdMux[ALT_SEL_BIT] = altSel_q;
      ADDR_PIN_DIR:     rdMux[PIN_DIR_BIT] = pinDir_q;
      default:          rdHit = 1'b0;
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= '0;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rdMux;
      s_axi_rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end
endmodule

/* testbench/ccu_compare_properties.sv */
// checker: port properties of the compare unit
`timescale 1ns/10ps
module ccu_compare_properties (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // register bus
  input wire logic s_axi_wvalid,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  // compare side
  input wire logic sleepMode,
  input wire logic adcEnabled,
  input wire logic adcStart,
  input wire logic specialTrigger,
  input wire logic ccpIrqFlag,
  input wire logic ccpPinMainOe,
  input wire logic ccpPinAltOe
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (srst);
  // flag next cycle, pins still released the cycle after
  sequence s_trig_effect;
    ##1 ccpIrqFlag ##1 (!ccpPinMainOe && !ccpPinAltOe);
  endsequence
  a_adc_start: assert property ((specialTrigger && adcEnabled) == adcStart)
    else $error("converter start differs from trigger");
  a_trig_effects: assert property (specialTrigger |-> s_trig_effect)
    else $error("trigger without flag or with pin driven");
  a_trig_pulse: assert property (specialTrigger |=> !specialTrigger)
    else $error("trigger longer than one cycle");
  a_sleep_quiet: assert property (sleepMode && $past(sleepMode) |-> !specialTrigger)
    else $error("trigger while sleeping");
  a_one_pin: assert property (!(ccpPinMainOe && ccpPinAltOe))
    else $error("both pin locations driven");
  // a software clear lands at the edge that raises the write response
  a_flag_holds: assert property (ccpIrqFlag |=>
    ccpIrqFlag || $rose(s_axi_bvalid))
    else $error("flag dropped without a write");
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered next cycle");
  a_write_done: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
    else $error("write response not released");
endmodule
bind ccu_compare_unit ccu_compare_properties chk (
  .ref_clk, .srst, .s_axi_wvalid, .s_axi_bvalid, .s_axi_bready,
  .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .sleepMode, .adcEnabled,
  .adcStart, .specialTrigger, .ccpIrqFlag, .ccpPinMainOe, .ccpPinAltOe
);

/* testbench/ccu_adc_model.sv */
// partner: converter model counting conversion starts
`timescale 1ns/10ps
module ccu_adc_model (
  // clock and reset
  input wire logic ref_clk,
  input wire logic srst,
  // converter control
  input wire logic enableReq,
  input wire logic adcStart,
  output logic     adcEnabled,
  output int       convCount
);
  assign adcEnabled = enableReq;
  always_ff @(posedge ref_clk) begin
    if (srst)
      convCount <= 0;
    else if (adcStart && adcEnabled)
      convCount <= convCount + 1;
  end
endmodule

/* testbench/tb_top.sv */
// testbench: compare unit driven over its register bus
`timescale 1ns/10ps
module tb_top;
  import ccu_pkg::*;
  typedef struct packed {
    logic [3:0] mode;
    logic       alt;
    logic       zero;
    logic       oe;
    logic       pin;
  } ccu_row_t;
  localparam logic [31:0] ZERO = 32'h0000_0000;
  localparam logic [31:0] ONE  = 32'h0000_0001;
  ccu_row_t rows [5] = '{'{MODE_SET, 0, 0, 1, 1}, '{MODE_TOGGLE, 1, 1, 1, 1},
    '{MODE_CLEAR, 0, 0, 1, 0}, '{MODE_SWIRQ, 0, 0, 0, 0},
    '{MODE_SPECIAL, 0, 0, 0, 0}};
  logic        ref_clk = 0;
  logic        srst = 1;
  logic [7:0]  s_axi_awaddr = 0;
  logic [7:0]  s_axi_araddr = 0;
  logic [31:0] s_axi_wdata = 0;
  logic [3:0]  s_axi_wstrb = 4'h1;
  logic        s_axi_awvalid = 0;
  logic        s_axi_wvalid = 0;
  logic        s_axi_bready = 0;
  logic        s_axi_arvalid = 0;
  logic        s_axi_rready = 0;
  logic        sleepMode = 0;
  logic        adcOn = 1;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic        s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rd;
  logic        adcEnabled, adcStart, specialTrigger, ccpIrqFlag;
  logic        ccpPinMain, ccpPinMainOe, ccpPinAlt, ccpPinAltOe;
  int          failures = 0;
  int          checks_done = 0;
  int          convCount;

  ccu_compare_unit DUT (
    .ref_clk, .srst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .sleepMode, .adcEnabled, .adcStart,
    .specialTrigger, .ccpIrqFlag, .ccpPinMain, .ccpPinMainOe, .ccpPinAlt,
    .ccpPinAltOe
  );
  ccu_adc_model ADC (
    .ref_clk, .srst, .enableReq(adcOn), .adcStart, .adcEnabled, .convCount
  );

  always #5 ref_clk = ~ref_clk;

  task automatic conclude;
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  task automatic timeout;
    failures++;
    conclude();
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    int n;
    aw = 1;
    w = 1;
    b = 0;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1;
    s_axi_wvalid  <= 1;
    s_axi_bready  <= 1;
    for (n = 0; n < 60 && !b; n++) begin
      @(negedge ref_clk);
      aw = aw && !s_axi_awready;
      w = w && !s_axi_wready;
      b = s_axi_bvalid;
      rr = s_axi_bresp;
      @(posedge ref_clk);
      s_axi_awvalid <= aw;
      s_axi_wvalid  <= w;
      s_axi_bready  <= !b;
    end
    if (!b) timeout();
  endtask

  task automatic rdr(input logic [7:0] a);
    logic ar, got;
    int n;
    ar = 1;
    got = 0;
    @(posedge ref_clk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1;
    s_axi_rready  <= 1;
    for (n = 0; n < 60 && !got; n++) begin
      @(negedge ref_clk);
      ar = ar && !s_axi_arready;
      got = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge ref_clk);
      s_axi_arvalid <= ar;
      s_axi_rready  <= !got;
    end
    if (!got) timeout();
  endtask

  // wait for the trigger (1) or the unit flag (0)
  task automatic wait_hi(input logic trig);
    for (int n = 0; n < 2000; n++) begin
      @(negedge ref_clk);
      if (trig ? specialTrigger : ccpIrqFlag) return;
    end
    timeout();
  endtask

  task automatic arm(input logic [31:0] mode, input logic alt, input logic z);
    wr(ADDR_T1_CONTROL, ZERO);
    wr(ADDR_T1_LOW, ZERO);
    wr(ADDR_T1_HIGH, ZERO);
    wr(ADDR_ALT_PIN, alt ? ONE : ZERO);
    if (z) wr(ADDR_CCP_CONTROL, ZERO);
    wr(ADDR_CCP_CONTROL, mode);
    wr(ADDR_IRQ_FLAGS, ZERO);
    wr(ADDR_T1_CONTROL, ONE);
  endtask

  initial begin
    repeat (12) @(posedge ref_clk);
    srst <= 0;
    rdr(ADDR_PIN_DIR);
    chk(rd, ONE);
    rdr(ADDR_CCP_CONTROL);
    chk(rd, ZERO);
    rdr(8'h30);
    chk(32'(rr), 32'(RESP_SLVERR));
    chk(rd, ZERO);
    wr(ADDR_PIN_DIR, ZERO);
    chk(32'(rr), 32'(RESP_OKAY));
    wr(8'h30, ONE);
    chk(32'(rr), 32'(RESP_SLVERR));
    wr(ADDR_CMP_LOW, 32'h0000_0002);
    wr(ADDR_CMP_HIGH, ONE);
    wr(ADDR_IRQ_ENABLE, 32'h0000_0004);
    // only byte lane zero may write
    s_axi_wstrb <= 4'h2;
    wr(ADDR_IRQ_ENABLE, ZERO);
    s_axi_wstrb <= 4'h1;
    rdr(ADDR_IRQ_ENABLE);
    chk(rd, 32'h0000_0004);
    for (int i = 0; i < 5; i++) begin
      arm(32'(rows[i].mode), rows[i].alt, rows[i].zero);
      wait_hi(0);
      repeat (3) @(negedge ref_clk);
      chk(32'({ccpPinMainOe, ccpPinAltOe}), 32'({rows[i].oe && !rows[i].alt,
        rows[i].oe && rows[i].alt}));
      if (rows[i].oe)
        chk(32'(rows[i].alt ? ccpPinAlt : ccpPinMain), 32'(rows[i].pin));
      wr(ADDR_T1_CONTROL, ZERO);
      rdr(ADDR_T1_HIGH);
      chk(rd, rows[i].mode == MODE_SPECIAL ? ZERO : ONE);
      rdr(ADDR_IRQ_FLAGS);
      chk(rd, 32'h0000_0004);
      chk(32'(convCount), 32'(rows[i].mode == MODE_SPECIAL));
    end
    // match removed before the timer tick that would clear it
    adcOn <= 0;
    arm(32'(MODE_SPECIAL), 0, 0);
    wait_hi(1);
    wr(ADDR_CMP_HIGH, 32'h0000_0002);
    repeat (8) @(posedge ref_clk);
    wr(ADDR_T1_CONTROL, ZERO);
    rdr(ADDR_T1_HIGH);
    chk(rd, ONE);
    chk(32'(convCount), ONE);
    sleepMode <= 1;
    wr(ADDR_CMP_HIGH, ZERO);
    wr(ADDR_CMP_LOW, 32'h0000_0003);
    arm(32'(MODE_SET), 0, 1);
    repeat (40) @(posedge ref_clk);
    rdr(ADDR_IRQ_FLAGS);
    chk(rd, ZERO);
    rdr(ADDR_T1_LOW);
    chk(rd, ZERO);
    // equality reached while asleep must wait for wake-up
    wr(ADDR_T1_LOW, 32'h0000_0003);
    repeat (4) @(negedge ref_clk);
    chk(32'(ccpIrqFlag), ZERO);
    @(posedge ref_clk);
    sleepMode <= 0;
    repeat (3) @(negedge ref_clk);
    chk(32'(ccpIrqFlag), ONE);
    chk(32'(ccpPinMain), ONE);
    conclude();
  end
endmodule
